// File: latched_byte_sram_port_tb.sv
// self-checking bench for the latched byte sram host port
`timescale 1ns/1ps
module latched_byte_sram_port_tb;
    reg clk = 1'h0, rst = 1'h1, vld = 1'h0, wr = 1'h0, slp = 1'h0;
    reg [11:0] adr = 12'h000;
    reg [15:0] wd = 16'h0000;
    reg [1:0] be = 2'h0;
    wire rdy, rsp, ale, ce_n, ub_n, lb_n, we_n, oe_n, hoe;
    wire [11:0] a;
    wire [15:0] rd, hdo, mdo, bus;
    integer bad_count = 0, n_tests = 0, cyc = 0;
    assign bus = hoe ? hdo : mdo;
    lbsp_host dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .req_valid_in(vld), .req_write_in(wr),
        .req_addr_in(adr), .req_wdata_in(wd), .req_byte_en_in(be), .req_sleep_in(slp),
        .req_ready_out(rdy), .rsp_valid_out(rsp), .rsp_rdata_out(rd), .word_address_out(a),
        .addr_latch_strobe_out(ale), .chip_enable_n_out(ce_n), .upper_byte_select_n_out(ub_n),
        .lower_byte_select_n_out(lb_n), .write_strobe_n_out(we_n), .output_enable_n_out(oe_n),
        .word_data_io_in(bus), .word_data_io_out(hdo), .word_data_io_oe_out(hoe));
    lbsp_sram_model mem_u (.word_address_in(a), .addr_latch_strobe_in(ale), .chip_enable_n_in(ce_n),
        .upper_byte_select_n_in(ub_n), .lower_byte_select_n_in(lb_n), .write_strobe_n_in(we_n),
        .output_enable_n_in(oe_n), .word_data_in(bus), .word_data_out(mdo));
    initial
        forever #12.5 clk = ~clk;
    // hang guard, well beyond the hundred or so cycles needed
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // one request held a single cycle, then wait for its answer
    task req(input w, input [11:0] ad, input [15:0] d, input [1:0] b);
        integer n;
    begin
        n = 0;
        while (rdy !== 1'h1 && n < 50)
        begin
            @(negedge clk);
            n = n + 1;
        end
        vld = 1'h1;
        wr = w;
        adr = ad;
        wd = d;
        be = b;
        @(negedge clk);
        vld = 1'h0;
        n = 0;
        while (rsp !== 1'h1 && n < 20)
        begin
            @(negedge clk);
            n = n + 1;
        end
        chk({15'h0000, rsp}, 16'h0001);
    end
    endtask
    task t_word;
    begin
        req(1'h1, 12'hFFF, 16'hA55A, 2'h3);
        req(1'h1, 12'h000, 16'h1234, 2'h3);
        req(1'h0, 12'hFFF, 16'h0000, 2'h3);
        chk(rd, 16'hA55A);
        req(1'h0, 12'h000, 16'h0000, 2'h3);
        chk(rd, 16'h1234);
        $display("test word done");
    end
    endtask
    task t_bytes;
    begin
        req(1'h1, 12'h010, 16'hFFFF, 2'h3);
        req(1'h1, 12'h010, 16'h0011, 2'h1);
        req(1'h1, 12'h010, 16'h2200, 2'h2);
        req(1'h0, 12'h010, 16'h0000, 2'h3);
        chk(rd, 16'h2211);
        req(1'h0, 12'h010, 16'h0000, 2'h1);
        chk(rd, 16'h0011);
        req(1'h0, 12'h010, 16'h0000, 2'h2);
        chk(rd, 16'h2200);
        $display("test bytes done");
    end
    endtask
    // asleep or no bytes enabled: nothing taken, memory powered down
    task t_idle;
        integer k;
    begin
        slp = 1'h1;
        vld = 1'h1;
        be = 2'h3;
        for (k = 0; k < 16; k = k + 1)
        begin
            @(negedge clk);
            chk({14'h0000, rsp, ce_n}, 16'h0001);
            slp = (k < 7);
            be = (k < 7) ? 2'h3 : 2'h0;
        end
        vld = 1'h0;
        $display("test idle done");
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        t_word;
        t_bytes;
        t_idle;
        final_report;
    end
endmodule

// File: lbsp_cnt.v
// small down counter used to time each phase of an access
`timescale 1ns/1ps
module lbsp_cnt #(
    parameter W = 4
)(
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire load_in,
    input wire [W-1:0] value_in,
    output wire done_out
);
    reg [W-1:0] cnt_ff;
    reg [W-1:0] nxt_cnt;

    // load wins over counting so a phase can restart at once
    always @*
    begin
        nxt_cnt = cnt_ff;
        if (load_in)
            nxt_cnt = value_in;
        else if (cnt_ff != {W{1'b0}})
            nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end

    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            cnt_ff <= {W{1'b0}};
        else
            cnt_ff <= nxt_cnt;
    end

    // done looks at the count only; gating it with load would loop back through the caller's load decode
    assign done_out = (cnt_ff == {W{1'b0}});
endmodule

// File: lbsp_defines.vh
// timing counts and widths for the latched byte sram host port
`ifndef LBSP_DEFINES_VH
`define LBSP_DEFINES_VH
`define LBSP_ADDR_W 12
`define LBSP_DATA_W 16
`define LBSP_CLK_PS 25000
// fastest grade figures in ns
`define LBSP_T_RC_NS 25
`define LBSP_T_AA_NS 24
`define LBSP_T_WP_NS 17
`define LBSP_T_WHZ_NS 13
`define LBSP_T_DW_NS 11
`define LBSP_T_AW_NS 25
`define LBSP_T_OHZ_NS 4
`define LBSP_T_CH_NS 10
// least times round up to whole cycles (at least one)
`define LBSP_CYC_UP(ns) ((((ns) * 1000) + `LBSP_CLK_PS - 1) / `LBSP_CLK_PS)
`define LBSP_RD_CYC (`LBSP_CYC_UP(`LBSP_T_AA_NS) + 1)
`define LBSP_WP_CYC `LBSP_CYC_UP(`LBSP_T_WP_NS)
`define LBSP_WHZ_CYC `LBSP_CYC_UP(`LBSP_T_WHZ_NS)
`define LBSP_DW_CYC `LBSP_CYC_UP(`LBSP_T_DW_NS)
`define LBSP_AW_CYC `LBSP_CYC_UP(`LBSP_T_AW_NS)
`define LBSP_OHZ_CYC `LBSP_CYC_UP(`LBSP_T_OHZ_NS)
`define LBSP_CH_CYC `LBSP_CYC_UP(`LBSP_T_CH_NS)
`endif

// File: lbsp_host.v
// host controller that drives a latched-address byte-select static memory
// Notes on behaviour
// - the write strobe stays high through every read access.
// - the address changes only while the write strobe and both byte selects are high.
// - with output enable low in a write, the strobe is stretched past turn-off plus data set-up.
// - data pins are not driven until the memory outputs have had time to turn off.
// - the write address is valid with zero set-up and held at least the address-to-end time.
`timescale 1ns/1ps
`include "lbsp_defines.vh"
module lbsp_host #(
    parameter AW = `LBSP_ADDR_W,
    parameter DW = `LBSP_DATA_W,
    parameter KEEP_OE_IN_WRITE = 0
)(
    input wire ref_clk_in,
    input wire sys_rst_in,
    // user request side
    input wire req_valid_in,
    input wire req_write_in,
    input wire [AW-1:0] req_addr_in,
    input wire [DW-1:0] req_wdata_in,
    input wire [1:0] req_byte_en_in,
    input wire req_sleep_in,
    output reg req_ready_out,
    output reg rsp_valid_out,
    output reg [DW-1:0] rsp_rdata_out,
    // memory pins
    output reg [AW-1:0] word_address_out,
    output reg addr_latch_strobe_out,
    output reg chip_enable_n_out,
    output reg upper_byte_select_n_out,
    output reg lower_byte_select_n_out,
    output reg write_strobe_n_out,
    output reg output_enable_n_out,
    input wire [DW-1:0] word_data_io_in,
    output reg [DW-1:0] word_data_io_out,
    output reg word_data_io_oe_out
);
    localparam CW = 4;
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_WOFF = 3'h3;
    localparam [2:0] ST_WDAT = 3'h4;
    localparam [2:0] ST_DONE = 3'h5;

    // counts in cycles, from the ns figures; cut to the counter width on purpose
    localparam integer RD_CYC_I = `LBSP_RD_CYC;
    localparam integer WHZ_CYC_I = `LBSP_WHZ_CYC;
    localparam integer OHZ_CYC_I = `LBSP_OHZ_CYC;
    localparam integer WP_CYC_I = `LBSP_WP_CYC;
    localparam integer DW_CYC_I = `LBSP_DW_CYC;
    localparam integer AW_CYC_I = `LBSP_AW_CYC;
    localparam integer CH_CYC_I = `LBSP_CH_CYC;
    localparam [CW-1:0] RD_CYC = RD_CYC_I[CW-1:0];
    localparam [CW-1:0] WHZ_CYC = WHZ_CYC_I[CW-1:0];
    localparam [CW-1:0] OHZ_CYC = OHZ_CYC_I[CW-1:0];
    localparam [CW-1:0] WP_CYC = WP_CYC_I[CW-1:0];
    localparam [CW-1:0] DW_CYC = DW_CYC_I[CW-1:0];
    localparam [CW-1:0] AW_CYC = AW_CYC_I[CW-1:0];
    localparam [CW-1:0] CH_CYC = CH_CYC_I[CW-1:0];

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg wr_ff;
    reg [1:0] ben_ff;
    reg [CW-1:0] load_val;
    reg load_cnt;
    reg [CW-1:0] wdat_len;
    wire cnt_done;

    lbsp_cnt #(.W(CW)) u_cnt (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(load_cnt),
        .value_in(load_val),
        .done_out(cnt_done)
    );

    // data phase of a write must cover both the pulse width and the address-to-end time
    always @*
    begin
        wdat_len = DW_CYC;
        if (WP_CYC > wdat_len)
            wdat_len = WP_CYC;
        if (AW_CYC > wdat_len)
            wdat_len = AW_CYC;
    end

    // phase sequencing
    always @*
    begin
        nxt_state = state_ff;
        load_cnt = 1'b0;
        load_val = {CW{1'b0}};
        case (state_ff)
            ST_IDLE:
            begin
                if (req_valid_in && !req_sleep_in && req_byte_en_in != 2'h0)
                begin
                    nxt_state = ST_ADDR;
                    load_cnt = 1'b1;
                    load_val = CH_CYC;
                end
            end
            ST_ADDR:
            begin
                // latch is open and address settled; access starts now
                if (cnt_done)
                begin
                    load_cnt = 1'b1;
                    if (wr_ff)
                    begin
                        nxt_state = ST_WOFF;
                        // outputs need turning off before we drive data
                        load_val = KEEP_OE_IN_WRITE ? WHZ_CYC : OHZ_CYC;
                    end
                    else
                    begin
                        nxt_state = ST_READ;
                        load_val = RD_CYC;
                    end
                end
            end
            ST_READ:
            begin
                if (cnt_done)
                    nxt_state = ST_DONE;
            end
            ST_WOFF:
            begin
                if (cnt_done)
                begin
                    nxt_state = ST_WDAT;
                    load_cnt = 1'b1;
                    load_val = wdat_len;
                end
            end
            ST_WDAT:
            begin
                if (cnt_done)
                    nxt_state = ST_DONE;
            end
            ST_DONE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // pin and handshake registers
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= ST_IDLE;
            wr_ff <= 1'b0;
            ben_ff <= 2'h0;
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {DW{1'b0}};
            word_address_out <= {AW{1'b0}};
            addr_latch_strobe_out <= 1'b0;
            chip_enable_n_out <= 1'b1;
            upper_byte_select_n_out <= 1'b1;
            lower_byte_select_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            word_data_io_out <= {DW{1'b0}};
            word_data_io_oe_out <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rsp_valid_out <= 1'b0;
            req_ready_out <= (nxt_state == ST_IDLE);
            // chip enable high puts the memory in power-down while idle
            chip_enable_n_out <= (nxt_state == ST_IDLE) || (nxt_state == ST_DONE);
            case (state_ff)
                ST_IDLE:
                begin
                    if (nxt_state == ST_ADDR)
                    begin
                        wr_ff <= req_write_in;
                        ben_ff <= req_byte_en_in;
                        // address moves only with strobe and both byte selects high
                        word_address_out <= req_addr_in;
                        word_data_io_out <= req_wdata_in;
                        addr_latch_strobe_out <= 1'b1;
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_done)
                    begin
                        upper_byte_select_n_out <= !ben_ff[1];
                        lower_byte_select_n_out <= !ben_ff[0];
                        // reads keep the strobe high; writes drop it with oe per option
                        write_strobe_n_out <= !wr_ff;
                        output_enable_n_out <= wr_ff ? !KEEP_OE_IN_WRITE : 1'b0;
                    end
                end
                ST_READ:
                begin
                    if (cnt_done)
                    begin
                        // unselected bytes float, so they read as zero here
                        rsp_rdata_out <= word_data_io_in & {{8{ben_ff[1]}}, {8{ben_ff[0]}}};
                        rsp_valid_out <= 1'b1;
                    end
                end
                ST_WOFF:
                begin
                    if (cnt_done)
                        word_data_io_oe_out <= 1'b1;
                end
                ST_WDAT:
                begin
                    if (cnt_done)
                    begin
                        // end the write first; data is held one more cycle (zero hold)
                        write_strobe_n_out <= 1'b1;
                        rsp_valid_out <= 1'b1;
                    end
                end
                ST_DONE:
                begin
                    write_strobe_n_out <= 1'b1;
                    output_enable_n_out <= 1'b1;
                    upper_byte_select_n_out <= 1'b1;
                    lower_byte_select_n_out <= 1'b1;
                    word_data_io_oe_out <= 1'b0;
                    // close the latch; the memory keeps the address held
                    addr_latch_strobe_out <= 1'b0;
                end
                default:
                    wr_ff <= 1'b0;
            endcase
        end
    end
endmodule

// File: lbsp_host_monitor.sv
// assertion checker for the latched byte sram host port
`timescale 1ns/1ps
module lbsp_host_monitor #(
    parameter AW = 12
)(
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire rsp_valid_out,
    input wire [AW-1:0] word_address_out,
    input wire addr_latch_strobe_out,
    input wire chip_enable_n_out,
    input wire upper_byte_select_n_out,
    input wire lower_byte_select_n_out,
    input wire write_strobe_n_out,
    input wire output_enable_n_out,
    input wire word_data_io_oe_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // a read never pulls the write strobe low
    property p_rd_we;
        !output_enable_n_out |-> write_strobe_n_out;
    endproperty
    a_rd_we: assert property (p_rd_we) else $error("write strobe low in read");
    // address moves only while the access is gated off
    property p_addr_mv;
        $changed(word_address_out) |-> write_strobe_n_out || chip_enable_n_out ||
            (upper_byte_select_n_out && lower_byte_select_n_out);
    endproperty
    a_addr_mv: assert property (p_addr_mv) else $error("address moved during write");
    // outputs stay disabled over the whole pulse: turn-off wait plus data phase, two cycles each
    property p_we_pulse;
        $fell(write_strobe_n_out) |-> (!write_strobe_n_out && output_enable_n_out)[*4] ##1 write_strobe_n_out;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse shape wrong");
    // data already on the pins before the write ends
    property p_dset;
        $rose(write_strobe_n_out) |-> $past(word_data_io_oe_out);
    endproperty
    a_dset: assert property (p_dset) else $error("data set-up missing");
    // memory outputs off a cycle before the host drives
    property p_no_fight;
        $rose(word_data_io_oe_out) |-> output_enable_n_out && $past(output_enable_n_out);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven over memory");
    // address latched and steady up to the end of the write
    property p_aw;
        $rose(write_strobe_n_out) |-> $stable(word_address_out) && $past(addr_latch_strobe_out, 2);
    endproperty
    a_aw: assert property (p_aw) else $error("write address not held");
    c_rd: cover property (rsp_valid_out && !output_enable_n_out);
    c_up: cover property (!write_strobe_n_out && !upper_byte_select_n_out && lower_byte_select_n_out);
    c_lo: cover property (!write_strobe_n_out && upper_byte_select_n_out && !lower_byte_select_n_out);
endmodule
bind lbsp_host lbsp_host_monitor #(.AW(AW)) mon_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .rsp_valid_out(rsp_valid_out), .word_address_out(word_address_out),
    .addr_latch_strobe_out(addr_latch_strobe_out), .chip_enable_n_out(chip_enable_n_out),
    .upper_byte_select_n_out(upper_byte_select_n_out), .lower_byte_select_n_out(lower_byte_select_n_out),
    .write_strobe_n_out(write_strobe_n_out), .output_enable_n_out(output_enable_n_out),
    .word_data_io_oe_out(word_data_io_oe_out));

// File: lbsp_sram_model.sv
// behavioural latched-address byte-select static memory
`timescale 1ns/1ps
module lbsp_sram_model (
    input wire [11:0] word_address_in,
    input wire addr_latch_strobe_in,
    input wire chip_enable_n_in,
    input wire upper_byte_select_n_in,
    input wire lower_byte_select_n_in,
    input wire write_strobe_n_in,
    input wire output_enable_n_in,
    input wire [15:0] word_data_in,
    output wire [15:0] word_data_out
);
    reg [15:0] mem_q [0:4095];
    reg [11:0] lat_q = 12'h000;
    wire [15:0] rd_w;
    wire wr_w;
    wire [1:0] drv_w;
    // transparent while strobe high, holds while low
    always @*
        if (addr_latch_strobe_in)
            lat_q = word_address_in;
    // data only valid after the access time
    assign #24 rd_w = mem_q[lat_q];
    assign wr_w = !chip_enable_n_in && !write_strobe_n_in;
    // each byte select gates its own byte of the write
    always @*
    begin
        if (wr_w && !upper_byte_select_n_in)
            mem_q[lat_q][15:8] = word_data_in[15:8];
        if (wr_w && !lower_byte_select_n_in)
            mem_q[lat_q][7:0] = word_data_in[7:0];
    end
    // undriven bytes show inverted data so stale values never match
    assign drv_w = {2{!chip_enable_n_in && !output_enable_n_in && write_strobe_n_in}} &
        ~{upper_byte_select_n_in, lower_byte_select_n_in};
    assign word_data_out = {drv_w[1] ? rd_w[15:8] : ~rd_w[15:8], drv_w[0] ? rd_w[7:0] : ~rd_w[7:0]};
endmodule
